// [arm_params.svh]
`ifndef ARM_PARAMS_SVH
`define ARM_PARAMS_SVH
// command opcodes
`define ARM_OP_NCQ_READ   8'h60
`define ARM_OP_MULT_READ  8'hC4
`define ARM_OP_MULT_EXT   8'h29
// device/head fields
`define ARM_DH_FUA        7
`define ARM_DH_LBA_MODE   6
`define ARM_DH_ADDR_MSB   3
`define ARM_DH_28         8'hE0
`define ARM_DH_NCQ        8'h40
// queue tag position in the sector-count field
`define ARM_TAG_MSB       7
`define ARM_TAG_LSB       3
// index of the last 16-bit word in a sector
`define ARM_WORDS_LAST    8'hFF
// full counts for a zero count field
`define ARM_FULL_28       17'h00100
`define ARM_FULL_48       17'h10000
`endif

// [arm_pkg.sv]
`default_nettype none
package arm_pkg;
  typedef enum logic [2:0] {
    ARM_IDLE  = 3'b000,
    ARM_FLUSH = 3'b100,
    ARM_FETCH = 3'b001,
    ARM_POST  = 3'b011,
    ARM_XFER  = 3'b010,
    ARM_DONE  = 3'b110
  } arm_state_t;

  typedef enum logic [1:0] {
    ARM_H_IDLE = 2'b00,
    ARM_H_RUN  = 2'b01
  } arm_hstate_t;

  // media status of one sector: bit0 correctable, bit1 uncorrectable
  typedef logic [1:0] arm_med_t;

  // sector total from a count field, zero meaning the full range
  function automatic logic [16:0] arm_sectors(input logic [15:0] c, input logic wide);
    if (wide)
      return (c == 16'h0000) ? 17'h10000 : {1'b0, c};
    else
      return (c[7:0] == 8'h00) ? 17'h00100 : {9'h000, c[7:0]};
  endfunction : arm_sectors

  // sectors in the next block: whole remainder for queued, else capped by block size
  function automatic logic [16:0] arm_block(input logic [16:0] rem, input logic [7:0] mult,
                                            input logic queued);
    if (queued || rem < {9'h000, mult})
      return rem;
    else
      return {9'h000, mult};
  endfunction : arm_block
endpackage : arm_pkg
`default_nettype wire

// [arm_link_if.sv]
`default_nettype none
interface arm_link_if;
  logic        tf_valid;
  logic [7:0]  tf_cmd;
  logic [7:0]  tf_devhead;
  logic [47:0] tf_lba;
  logic [15:0] tf_count;
  logic [15:0] tf_feat;
  logic        bsy;
  logic        drq;
  logic        err;
  logic        abrt;
  logic        unc;
  logic        corr;
  logic        intrq;
  logic [47:0] lba_out;
  logic        done;
  logic [4:0]  done_tag;
  logic [15:0] dat;
  logic        dat_valid;
  logic        dat_ack;

  modport dev (input tf_valid, tf_cmd, tf_devhead, tf_lba, tf_count, tf_feat, dat_ack,
               output bsy, drq, err, abrt, unc, corr, intrq, lba_out, done, done_tag, dat, dat_valid);
  modport host (output tf_valid, tf_cmd, tf_devhead, tf_lba, tf_count, tf_feat, dat_ack,
                input bsy, drq, err, abrt, unc, corr, intrq, lba_out, done, done_tag, dat, dat_valid);
endinterface : arm_link_if
`default_nettype wire

// [arm_dev.sv]
// Behaviour
// R01 - FUA read fetches from media, not cache
// R02 - FUA flushes dirty cache before media read
// R03 - without FUA, cache or media may serve
// R04 - queued read needs NCQ, opcode 60h
// R05 - queued count in features, zero means 65536
// R06 - tag in count bits, completion reports tag
// R07 - one interrupt per block, not per sector
// R08 - data request only at block start
// R09 - host loads total sectors, not blocks
// R10 - trailing partial block holds the remainder
// R11 - abort without block size or when disabled
// R12 - block errors posted at start, data still sent
// R13 - interrupt with each block data request; queued reads raise none until done
// R14 - 28-bit read 1..256 sectors, zero means 256
// R15 - 48-bit read 1..65536, zero means 65536
// R16 - error leaves failing sector address reported
// R17 - only correctable errors continue past block
// R18 - success reports last sector address read
// R19 - 48-bit opcode 29h, high bytes previous
// R20 - block size one accepted, larger allowed
// R21 - 28-bit opcode C4h, head bits 27:24
`include "arm_params.svh"
`default_nettype none
module arm_dev (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  arm_link_if.dev           lk,
  input  wire logic [7:0]   mult_block,
  input  wire logic         mult_en,
  input  wire logic         ncq_en,
  input  wire logic         cache_dirty,
  output logic              med_req,
  output logic [47:0]       med_lba,
  output logic              med_bypass,
  input  wire logic         med_ack,
  input  wire arm_pkg::arm_med_t med_status,
  output logic              med_flush,
  input  wire logic         med_flush_done,
  input  wire logic [15:0]  med_word,
  output logic              med_take
);
  import arm_pkg::*;
  arm_state_t  state_reg,   state_next;
  logic [47:0] lba_reg,     lba_next;
  logic [47:0] err_lba_reg, err_lba_next;
  logic [47:0] out_reg,     out_next;
  logic [16:0] remain_reg,  remain_next;
  logic [16:0] blk_reg,     blk_next;
  logic [16:0] fcnt_reg,    fcnt_next; // sectors fetched, then sectors sent, in one block
  logic [7:0]  word_reg,    word_next;
  logic [1:0]  berr_reg,    berr_next;
  logic [4:0]  tag_reg,     tag_next;
  logic [15:0] dat_reg,     dat_next;
  logic        ncq_reg,     ncq_next;
  logic        fua_reg,     fua_next;
  logic        req_reg,     req_next;
  logic        bsy_reg,     bsy_next;
  logic        drq_reg,     drq_next;
  logic        err_reg,     err_next;
  logic        abrt_reg,    abrt_next;
  logic        unc_reg,     unc_next;
  logic        corr_reg,    corr_next;
  logic        intrq_reg,   intrq_next;
  logic        done_reg,    done_next;
  logic        dval_reg,    dval_next;
  logic        take_reg,    take_next;
  logic        flush_reg,   flush_next;
  logic        is_mult, is_ncq, is_28;
  logic [16:0] req_secs;
  // command decode of the incoming task file
  always_comb begin
    is_mult  = (lk.tf_cmd == `ARM_OP_MULT_READ) || (lk.tf_cmd == `ARM_OP_MULT_EXT); // R19 R21
    is_ncq   = (lk.tf_cmd == `ARM_OP_NCQ_READ); // R04
    is_28    = (lk.tf_cmd == `ARM_OP_MULT_READ);
    req_secs = is_ncq ? arm_sectors(lk.tf_feat, 1'b1) // R05
                      : arm_sectors(lk.tf_count, !is_28); // R14 R15
  end

  // command sequencer next state
  always_comb begin
    state_next   = state_reg;
    lba_next     = lba_reg;
    err_lba_next = err_lba_reg;
    out_next     = out_reg;
    remain_next  = remain_reg;
    blk_next     = blk_reg;
    fcnt_next    = fcnt_reg;
    word_next    = word_reg;
    berr_next    = berr_reg;
    tag_next     = tag_reg;
    dat_next     = dat_reg;
    ncq_next     = ncq_reg;
    fua_next     = fua_reg;
    req_next     = req_reg;
    bsy_next     = bsy_reg;
    drq_next     = drq_reg;
    err_next     = err_reg;
    abrt_next    = abrt_reg;
    unc_next     = unc_reg;
    corr_next    = corr_reg;
    dval_next    = dval_reg;
    intrq_next   = 1'b0;
    done_next    = 1'b0;
    take_next    = 1'b0;
    flush_next   = 1'b0;
    case (state_reg)
      ARM_IDLE: begin
        if (lk.tf_valid) begin
          err_next  = 1'b0;
          abrt_next = 1'b0;
          unc_next  = 1'b0;
          corr_next = 1'b0;
          berr_next = 2'b00;
          fcnt_next = 17'h00000;
          if ((is_mult && (mult_block == 8'h00 || !mult_en)) || (is_ncq && !ncq_en) ||
              !(is_mult || is_ncq)) begin
            err_next   = 1'b1; // R11 R04
            abrt_next  = 1'b1;
            state_next = ARM_DONE;
          end else begin
            bsy_next    = 1'b1;
            ncq_next    = is_ncq;
            fua_next    = is_ncq && lk.tf_devhead[`ARM_DH_FUA]; // R01 R03
            tag_next    = lk.tf_count[`ARM_TAG_MSB:`ARM_TAG_LSB]; // R06
            lba_next    = is_28 ? {20'h00000, lk.tf_devhead[`ARM_DH_ADDR_MSB:0], lk.tf_lba[23:0]} // R21
                                : lk.tf_lba; // R19
            remain_next = req_secs; // R09
            blk_next    = arm_block(req_secs, mult_block, is_ncq); // R10 R20
            if (is_ncq && lk.tf_devhead[`ARM_DH_FUA] && cache_dirty) begin
              flush_next = 1'b1; // R02
              state_next = ARM_FLUSH;
            end else begin
              req_next   = 1'b1;
              state_next = ARM_FETCH;
            end
          end
        end
      end
      ARM_FLUSH: begin
        if (med_flush_done) begin
          req_next   = 1'b1; // R02
          state_next = ARM_FETCH;
        end
      end
      ARM_FETCH: begin
        if (med_ack) begin
          lba_next  = lba_reg + 48'h000000000001;
          fcnt_next = fcnt_reg + 17'h00001;
          if (med_status != 2'b00 && berr_reg == 2'b00)
            err_lba_next = lba_reg; // R16
          berr_next = berr_reg | med_status;
          if (fcnt_reg + 17'h00001 == blk_reg) begin
            req_next   = 1'b0;
            state_next = ARM_POST;
          end
        end
      end
      ARM_POST: begin
        drq_next   = 1'b1; // R08
        bsy_next   = 1'b0;
        intrq_next = !ncq_reg; // R07 R13
        err_next   = berr_reg != 2'b00; // R12
        unc_next   = berr_reg[1];
        corr_next  = berr_reg[0];
        dval_next  = 1'b1;
        dat_next   = med_word;
        take_next  = 1'b1;
        fcnt_next  = 17'h00000;
        state_next = ARM_XFER;
      end
      ARM_XFER: begin
        if (dval_reg && lk.dat_ack) begin
          dval_next = 1'b0;
          word_next = word_reg + 8'h01;
          if (word_reg == `ARM_WORDS_LAST) begin
            fcnt_next = fcnt_reg + 17'h00001;
            if (fcnt_reg + 17'h00001 == blk_reg) begin
              drq_next    = 1'b0;
              remain_next = remain_reg - blk_reg;
              out_next    = berr_reg[1] ? err_lba_reg : lba_reg - 48'h000000000001; // R16 R18
              if (berr_reg[1] || remain_reg == blk_reg) begin
                state_next = ARM_DONE; // R17
              end else begin
                blk_next   = arm_block(remain_reg - blk_reg, mult_block, ncq_reg); // R10
                berr_next  = 2'b00;
                fcnt_next  = 17'h00000;
                bsy_next   = 1'b1;
                req_next   = 1'b1;
                state_next = ARM_FETCH; // R17
              end
            end
          end
        end else if (!dval_reg) begin
          dval_next = 1'b1;
          dat_next  = med_word;
          take_next = 1'b1;
        end
      end
      ARM_DONE: begin
        bsy_next   = 1'b0;
        drq_next   = 1'b0;
        done_next  = 1'b1; // R06
        intrq_next = ncq_reg || abrt_reg;
        state_next = ARM_IDLE;
      end
      default: begin
        state_next = ARM_IDLE;
      end
    endcase
  end

  // state registers, frozen while ce is low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg                        <= ARM_IDLE;
      {lba_reg, err_lba_reg, out_reg}  <= 144'h0;
      {remain_reg, blk_reg, fcnt_reg}  <= 51'h0;
      {word_reg, berr_reg, tag_reg}    <= 15'h0000;
      dat_reg                          <= 16'h0000;
      {ncq_reg, fua_reg, req_reg, bsy_reg, drq_reg, err_reg, abrt_reg, unc_reg, corr_reg, intrq_reg, done_reg,
       dval_reg, take_reg, flush_reg} <= 14'h0000;
    end else if (ce) begin
      state_reg   <= state_next;
      lba_reg     <= lba_next;
      err_lba_reg <= err_lba_next;
      out_reg     <= out_next;
      remain_reg  <= remain_next;
      blk_reg     <= blk_next;
      fcnt_reg    <= fcnt_next;
      word_reg    <= word_next;
      berr_reg    <= berr_next;
      tag_reg     <= tag_next;
      dat_reg     <= dat_next;
      ncq_reg     <= ncq_next;
      fua_reg     <= fua_next;
      req_reg     <= req_next;
      bsy_reg     <= bsy_next;
      drq_reg     <= drq_next;
      err_reg     <= err_next;
      abrt_reg    <= abrt_next;
      unc_reg     <= unc_next;
      corr_reg    <= corr_next;
      intrq_reg   <= intrq_next;
      done_reg    <= done_next;
      dval_reg    <= dval_next;
      take_reg    <= take_next;
      flush_reg   <= flush_next;
    end
  end

  // outputs straight from registers
  assign lk.bsy      = bsy_reg;
  assign lk.drq      = drq_reg;
  assign lk.err      = err_reg;
  assign lk.abrt     = abrt_reg;
  assign lk.unc      = unc_reg;
  assign lk.corr     = corr_reg;
  assign lk.intrq    = intrq_reg;
  assign lk.lba_out  = out_reg;
  assign lk.done     = done_reg;
  assign lk.done_tag = tag_reg;
  assign lk.dat      = dat_reg;
  assign lk.dat_valid = dval_reg;
  assign med_req     = req_reg;
  assign med_lba     = lba_reg;
  assign med_bypass  = fua_reg; // R01 R03
  assign med_flush   = flush_reg;
  assign med_take    = take_reg;
endmodule : arm_dev
`default_nettype wire

// [arm_host.sv]
`include "arm_params.svh"
`default_nettype none
module arm_host (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  arm_link_if.host          lk,
  input  wire logic         usr_start,
  input  wire logic [7:0]   usr_cmd,
  input  wire logic [47:0]  usr_lba,
  input  wire logic [15:0]  usr_count,
  input  wire logic         usr_fua,
  input  wire logic [4:0]   usr_tag,
  output logic              usr_busy,
  output logic [15:0]       usr_word,
  output logic              usr_word_valid,
  output logic              usr_blk_irq,
  output logic              usr_done,
  output logic              usr_err,
  output logic              usr_abrt,
  output logic [47:0]       usr_lba_res,
  output logic [4:0]        usr_done_tag
);
  import arm_pkg::*;

  arm_hstate_t state_reg, state_next;
  logic        tfv_reg,   tfv_next;
  logic [7:0]  cmd_reg,   cmd_next;
  logic [7:0]  dh_reg,    dh_next;
  logic [47:0] lba_reg,   lba_next;
  logic [15:0] cnt_reg,   cnt_next;
  logic [15:0] feat_reg,  feat_next;
  logic        ack_reg,   ack_next;
  logic        busy_reg,  busy_next;
  logic [15:0] word_reg,  word_next;
  logic        wv_reg,    wv_next;
  logic        irq_reg,   irq_next;
  logic        done_reg,  done_next;
  logic        err_reg,   err_next;
  logic        abrt_reg,  abrt_next;
  logic [47:0] res_reg,   res_next;
  logic [4:0]  tag_reg,   tag_next;

  // issue, data acceptance and completion next state
  always_comb begin
    state_next = state_reg;
    cmd_next   = cmd_reg;
    dh_next    = dh_reg;
    lba_next   = lba_reg;
    cnt_next   = cnt_reg;
    feat_next  = feat_reg;
    busy_next  = busy_reg;
    word_next  = word_reg;
    err_next   = err_reg;
    abrt_next  = abrt_reg;
    res_next   = res_reg;
    tag_next   = tag_reg;
    tfv_next   = 1'b0;
    ack_next   = 1'b0;
    wv_next    = 1'b0;
    irq_next   = lk.intrq;
    done_next  = 1'b0;
    case (state_reg)
      ARM_H_IDLE: begin
        if (usr_start && !lk.bsy) begin
          tfv_next  = 1'b1;
          busy_next = 1'b1;
          cmd_next  = usr_cmd;
          lba_next  = usr_lba;
          feat_next = 16'h0000;
          cnt_next  = usr_count; // R09
          if (usr_cmd == `ARM_OP_NCQ_READ) begin
            dh_next   = `ARM_DH_NCQ | {usr_fua, 7'h00}; // R01
            feat_next = usr_count; // R05
            cnt_next  = {8'h00, usr_tag, 3'b000}; // R06
          end else if (usr_cmd == `ARM_OP_MULT_READ)
            dh_next = `ARM_DH_28 | {4'h0, usr_lba[27:24]}; // R21
          else
            dh_next = `ARM_DH_28; // R19
          state_next = ARM_H_RUN;
        end
      end
      ARM_H_RUN: begin
        if (lk.dat_valid && !ack_reg) begin
          ack_next  = 1'b1; // R08
          word_next = lk.dat;
          wv_next   = 1'b1;
        end
        if (lk.done) begin
          done_next  = 1'b1;
          busy_next  = 1'b0;
          err_next   = lk.err;
          abrt_next  = lk.abrt;
          res_next   = lk.lba_out;
          tag_next   = lk.done_tag; // R06
          state_next = ARM_H_IDLE;
        end
      end
      default: begin
        state_next = ARM_H_IDLE;
      end
    endcase
  end

  // state registers, frozen while ce is low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ARM_H_IDLE;
      tfv_reg   <= 1'b0;
      cmd_reg   <= 8'h00;
      dh_reg    <= 8'h00;
      lba_reg   <= 48'h000000000000;
      cnt_reg   <= 16'h0000;
      feat_reg  <= 16'h0000;
      ack_reg   <= 1'b0;
      busy_reg  <= 1'b0;
      word_reg  <= 16'h0000;
      wv_reg    <= 1'b0;
      irq_reg   <= 1'b0;
      done_reg  <= 1'b0;
      err_reg   <= 1'b0;
      abrt_reg  <= 1'b0;
      res_reg   <= 48'h000000000000;
      tag_reg   <= 5'h00;
    end else if (ce) begin
      state_reg <= state_next;
      tfv_reg   <= tfv_next;
      cmd_reg   <= cmd_next;
      dh_reg    <= dh_next;
      lba_reg   <= lba_next;
      cnt_reg   <= cnt_next;
      feat_reg  <= feat_next;
      ack_reg   <= ack_next;
      busy_reg  <= busy_next;
      word_reg  <= word_next;
      wv_reg    <= wv_next;
      irq_reg   <= irq_next;
      done_reg  <= done_next;
      err_reg   <= err_next;
      abrt_reg  <= abrt_next;
      res_reg   <= res_next;
      tag_reg   <= tag_next;
    end
  end

  // outputs straight from registers
  assign lk.tf_valid   = tfv_reg;
  assign lk.tf_cmd     = cmd_reg;
  assign lk.tf_devhead = dh_reg;
  assign lk.tf_lba     = lba_reg;
  assign lk.tf_count   = cnt_reg;
  assign lk.tf_feat    = feat_reg;
  assign lk.dat_ack    = ack_reg;
  assign usr_busy       = busy_reg;
  assign usr_word       = word_reg;
  assign usr_word_valid = wv_reg;
  assign usr_blk_irq    = irq_reg;
  assign usr_done       = done_reg;
  assign usr_err        = err_reg;
  assign usr_abrt       = abrt_reg;
  assign usr_lba_res    = res_reg;
  assign usr_done_tag   = tag_reg;
endmodule : arm_host
`default_nettype wire

// [arm_link_sva.sv]
`default_nettype none
module arm_link_sva (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        tf_valid,
  input wire logic [7:0]  tf_cmd,
  input wire logic [47:0] tf_lba,
  input wire logic [15:0] tf_count,
  input wire logic        bsy,
  input wire logic        drq,
  input wire logic        err,
  input wire logic        abrt,
  input wire logic        unc,
  input wire logic        intrq,
  input wire logic [47:0] lba_out,
  input wire logic        done,
  input wire logic [4:0]  done_tag,
  input wire logic [15:0] dat,
  input wire logic        dat_valid,
  input wire logic        dat_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // an opcode outside the three reads is taken
  sequence bad_op_s;
    tf_valid && !bsy && tf_cmd != 8'h60 && tf_cmd != 8'hC4 && tf_cmd != 8'h29;
  endsequence
  // status first, then completion with interrupt
  sequence abort_s;
    err && abrt ##1 done && intrq;
  endsequence
  // checks on the link
  abort_order_a: assert property (bad_op_s |=> abort_s) else $error("abort order wrong");
  block_irq_a: assert property ($rose(drq) && tf_cmd != 8'h60 |-> intrq) else $error("no block irq");
  irq_start_a: assert property (intrq && !done |-> $rose(drq)) else $error("irq off block start");
  drq_ready_a: assert property (drq |-> !bsy) else $error("drq with bsy");
  data_hold_a: assert property (dat_valid && !dat_ack |=> dat_valid && $stable(dat))
    else $error("data word dropped");
  unc_stop_a: assert property ($fell(drq) && unc |-> ##[0:3] (done && !bsy))
    else $error("no stop after bad block");
  ncq_tag_a: assert property (done && !abrt && tf_cmd == 8'h60 |-> done_tag == tf_count[7:3])
    else $error("wrong done tag");
  last_lba_a: assert property (done && !err && tf_cmd == 8'h29 && tf_count != 16'h0000
    |-> lba_out == tf_lba + {32'h0, tf_count} - 48'h1) else $error("wrong last address");
endmodule : arm_link_sva
`default_nettype wire

// [ata_read_multiple_ncq_cmds_bench.sv]
`default_nettype none
module ata_read_multiple_ncq_cmds_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import arm_pkg::*;
  logic        clk = 1'b0, resetn = 1'b0;
  logic [7:0]  mult_block = 8'h00;
  logic        mult_en = 1'b0, ncq_en = 1'b0, cache_dirty = 1'b0;
  logic        med_req, med_bypass, med_flush, med_take, med_ack = 1'b0, med_flush_done = 1'b0;
  logic [47:0] med_lba, bad_lba = 48'hFFFFFFFFFFFF;
  arm_med_t    med_status = 2'b00, bad_kind = 2'b00;
  logic [15:0] med_word = 16'h0000, usr_count = 16'h0000, usr_word;
  logic        usr_start = 1'b0, usr_fua = 1'b0, byp = 1'b0;
  logic [7:0]  usr_cmd = 8'h00;
  logic [47:0] usr_lba = 48'h0, usr_lba_res;
  logic [4:0]  usr_tag = 5'h00, usr_done_tag;
  logic        usr_busy, usr_word_valid, usr_blk_irq, usr_done, usr_err, usr_abrt;
  logic [7:0]  ops [4] = '{8'hC4, 8'h29, 8'h60, 8'h61};
  int          failures = 0, tests_run = 0, words = 0, irqs = 0, flushes = 0, next_word = 0;

  arm_link_if lk ();
  arm_dev arm_dev_i (.clk, .resetn, .ce(1'b1), .lk(lk.dev), .mult_block, .mult_en, .ncq_en,
    .cache_dirty, .med_req, .med_lba, .med_bypass, .med_ack, .med_status, .med_flush,
    .med_flush_done, .med_word, .med_take);
  arm_host arm_host_i (.clk, .resetn, .ce(1'b1), .lk(lk.host), .usr_start, .usr_cmd, .usr_lba,
    .usr_count, .usr_fua, .usr_tag, .usr_busy, .usr_word, .usr_word_valid, .usr_blk_irq,
    .usr_done, .usr_err, .usr_abrt, .usr_lba_res, .usr_done_tag);
  arm_link_sva arm_link_sva_i (.clk, .resetn, .tf_valid(lk.tf_valid), .tf_cmd(lk.tf_cmd),
    .tf_lba(lk.tf_lba), .tf_count(lk.tf_count), .bsy(lk.bsy), .drq(lk.drq), .err(lk.err),
    .abrt(lk.abrt), .unc(lk.unc), .intrq(lk.intrq), .lba_out(lk.lba_out), .done(lk.done),
    .done_tag(lk.done_tag), .dat(lk.dat), .dat_valid(lk.dat_valid), .dat_ack(lk.dat_ack));

  // clock of 25 ns
  initial begin
    forever #12.5 clk = ~clk;
  end

  // media answers every other cycle and flags one chosen sector
  always @(posedge clk) begin
    med_ack <= med_req & ~med_ack;
    med_status <= (med_lba == bad_lba) ? bad_kind : 2'b00;
    med_flush_done <= med_flush;
    if (med_take) med_word <= med_word + 16'h0001;
    if (med_flush) flushes++;
    if (med_req && med_bypass) byp = 1'b1;
    if (usr_word_valid) begin
      chk(usr_word, next_word, "word order");
      next_word++;
      words++;
    end
    if (usr_blk_irq) irqs++;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk

  // device setup and the sector that goes bad
  task automatic cfg(input logic [7:0] b, input logic e, input logic q, input logic d,
                     input logic [47:0] bl, input arm_med_t bk);
    @(posedge clk);
    mult_block <= b;
    mult_en <= e;
    ncq_en <= q;
    cache_dirty <= d;
    bad_lba <= bl;
    bad_kind <= bk;
  endtask : cfg

  // one command from start to done
  task automatic run(input logic [7:0] c, input logic [47:0] a, input logic [15:0] n,
                     input logic f, input logic [4:0] t);
    int k;
    @(negedge clk);
    words = 0;
    irqs = 0;
    flushes = 0;
    byp = 1'b0;
    @(posedge clk);
    usr_cmd <= c;
    usr_lba <= a;
    usr_count <= n;
    usr_fua <= f;
    usr_tag <= t;
    usr_start <= 1'b1;
    @(posedge clk);
    usr_start <= 1'b0;
    for (k = 0; k < 20000 && usr_done !== 1'b1; k++) @(negedge clk);
    if (k == 20000) begin
      chk(1'b0, 1'b1, "command timeout");
      complete_run();
    end
    repeat (3) @(negedge clk);
  endtask : run

  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    cfg(8'h02, 1'b1, 1'b1, 1'b0, 48'hFFFFFFFFFFFF, 2'b00);
    run(8'hC4, 48'h00000A123456, 16'h0005, 1'b0, 5'h00);
    chk(words, 1280, "partial block words");
    chk(irqs, 3, "block irqs");
    chk(usr_lba_res, 48'h00000A12345A, "28-bit last address");
    chk(usr_err, 1'b0, "clean error");
    cfg(8'h03, 1'b1, 1'b1, 1'b0, 48'hFFFFFFFFFFFF, 2'b00);
    run(8'h29, 48'hA1B2C3D4E5F0, 16'h0003, 1'b0, 5'h00);
    chk(words, 768, "48-bit words");
    chk(irqs, 1, "one block irq");
    chk(usr_lba_res, 48'hA1B2C3D4E5F2, "48-bit last address");
    cfg(8'h01, 1'b1, 1'b1, 1'b0, 48'h000000000101, 2'b01);
    run(8'hC4, 48'h000000000100, 16'h0003, 1'b0, 5'h00);
    chk(words, 768, "correctable continues");
    chk(irqs, 3, "block of one");
    cfg(8'h02, 1'b1, 1'b1, 1'b0, 48'h000000200001, 2'b10);
    run(8'h29, 48'h000000200000, 16'h0006, 1'b0, 5'h00);
    chk(words, 512, "bad block sent");
    chk(irqs, 1, "stop after bad block");
    chk(usr_err, 1'b1, "error posted");
    chk(usr_lba_res, 48'h000000200001, "failing address");
    cfg(8'h02, 1'b1, 1'b1, 1'b1, 48'hFFFFFFFFFFFF, 2'b00);
    run(8'h60, 48'h000000300000, 16'h0002, 1'b1, 5'h13);
    chk(words, 512, "queued words");
    chk(flushes, 1, "flush before read");
    chk(byp, 1'b1, "cache bypass");
    chk(usr_done_tag, 5'h13, "queued tag");
    chk(irqs, 1, "queued done irq");
    run(8'h60, 48'h000000300000, 16'h0001, 1'b0, 5'h04);
    chk(flushes, 0, "no flush");
    chk(byp, 1'b0, "cache allowed");
    chk(usr_done_tag, 5'h04, "second tag");
    for (int i = 0; i < 4; i++) begin
      cfg((i == 0) ? 8'h00 : 8'h02, i != 1, i != 2, 1'b0, 48'hFFFFFFFFFFFF, 2'b00);
      run(ops[i], 48'h000000000010, 16'h0001, 1'b0, 5'h00);
      chk(usr_abrt, 1'b1, "aborted");
      chk(words, 0, "no data on abort");
    end
    complete_run();
  end
endmodule : ata_read_multiple_ncq_cmds_bench
`default_nettype wire
